// ---- verilog/pmc_macrocell.v ----
// Purpose: one configurable output macrocell with pin feedback and input element
// Assumes: all pins and product terms synchronous to CLOCK_I; cell clocks are edge-detected
// Notes: configuration is writable only while the run bit is low
`include "pmc_defines.vh"
module pmc_macrocell #(
	parameter NPINS = 4
) (
	input wire CLOCK_I,
	input wire RSTN_I,
	input wire [`PMC_AW-1:0] S_AXI_AWADDR_I,
	input wire S_AXI_AWVALID_I,
	output wire S_AXI_AWREADY_O,
	input wire [31:0] S_AXI_WDATA_I,
	input wire [3:0] S_AXI_WSTRB_I,
	input wire S_AXI_WVALID_I,
	output wire S_AXI_WREADY_O,
	output wire [1:0] S_AXI_BRESP_O,
	output wire S_AXI_BVALID_O,
	input wire S_AXI_BREADY_I,
	input wire [`PMC_AW-1:0] S_AXI_ARADDR_I,
	input wire S_AXI_ARVALID_I,
	output wire S_AXI_ARREADY_O,
	output wire [31:0] S_AXI_RDATA_O,
	output wire [1:0] S_AXI_RRESP_O,
	output wire S_AXI_RVALID_O,
	input wire S_AXI_RREADY_I,
	input wire [NPINS-1:0] COMMON_PINS_I,
	input wire PT_D_I,
	input wire PT_K_I,
	input wire PT_CE_I,
	input wire PT_CLK_I,
	input wire PT_OE_I,
	input wire PT_AP_I,
	input wire PT_AR_I,
	input wire PT_SP_I,
	input wire PT_SR_I,
	input wire PT_LE_I,
	input wire PT_PIN_FB_REG_CLK_I,
	input wire PT_PIN_FB_REG_APRESET_I,
	input wire PT_PIN_FB_REG_ARESET_I,
	input wire PT_PIN_FB_REG_SPRESET_I,
	input wire PT_PIN_FB_REG_SRESET_I,
	input wire IO_PIN_I,
	input wire IO_PIN2_I,
	output wire IO_PIN_O,
	output wire IO_PIN_OE_O,
	input wire IN_PIN_I,
	output wire FB_O,
	output wire IN_FB_O
);

	// pins outside the fitted set read as low, so a narrow variant cannot pick a pin it does not have
	function pick;
		input [NPINS-1:0] pins;
		input [1:0] sel;
		begin
			pick = (sel < NPINS) ? pins[sel] : 1'b0;
		end
	endfunction

	// byte-lane merge for partial writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = data[i*8 +: 8];
				end
			end
		end
	endfunction

	reg [31:0] cfg_reg;
	reg run_reg;
	reg aw_have_reg;
	reg w_have_reg;
	reg [`PMC_AW-1:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg rvalid_reg;
	reg [1:0] rresp_reg;
	reg [31:0] rdata_reg;
	reg q_reg;
	reg q_next;
	reg latch_reg;
	reg clk_prev_reg;
	reg pfb_reg;
	reg pfb_next;
	reg pfb_lat_reg;
	reg pfb_clk_prev_reg;
	reg in_reg;
	reg in_lat_reg;
	reg fb_sel;

	// configuration fields; a single select field per mux makes sources exclusive
	wire [2:0] st_type = cfg_reg[`PMC_TYPE_MSB:`PMC_TYPE_LSB];
	wire is_comb = cfg_reg[`PMC_B_COMB];
	wire ck_com = cfg_reg[`PMC_B_CK_COM];
	wire oe_com = cfg_reg[`PMC_B_OE_COM];
	wire [2:0] fb_mode = cfg_reg[`PMC_FB_MSB:`PMC_FB_LSB];
	wire [1:0] ck_pin = cfg_reg[`PMC_CK_LSB +: 2];
	wire [1:0] oe_pin = cfg_reg[`PMC_OE_LSB +: 2];
	wire [1:0] ap_pin = cfg_reg[`PMC_AP_LSB +: 2];
	wire [1:0] ar_pin = cfg_reg[`PMC_AR_LSB +: 2];
	wire [1:0] le_pin = cfg_reg[`PMC_LE_LSB +: 2];

	// common sources take one pin, with an optional inversion for clock and enable only, never array logic
	wire com_clk = pick(COMMON_PINS_I, ck_pin) ^ cfg_reg[`PMC_B_CK_INV];
	wire com_oe = pick(COMMON_PINS_I, oe_pin) ^ cfg_reg[`PMC_B_OE_INV];
	wire cell_clk = ck_com ? com_clk : PT_CLK_I;
	wire cell_oe = oe_com ? com_oe : PT_OE_I;
	wire ap_act = cfg_reg[`PMC_B_AP_PIN] ? pick(COMMON_PINS_I, ap_pin) : PT_AP_I;
	wire ar_act = cfg_reg[`PMC_B_AR_PIN] ? pick(COMMON_PINS_I, ar_pin) : PT_AR_I;
	wire le_act = cfg_reg[`PMC_B_LE_PIN] ? pick(COMMON_PINS_I, le_pin) : PT_LE_I;
	wire clk_rise = cell_clk & ~clk_prev_reg;
	wire pfb_rise = PT_PIN_FB_REG_CLK_I & ~pfb_clk_prev_reg;

	// transparent latch passes D while its gate is high
	wire latch_q = le_act ? PT_D_I : latch_reg;
	wire store_q = (st_type == `PMC_T_LAT) ? latch_q : q_reg;
	// asynchronous controls override the stored value without waiting for an edge
	wire q_out = ar_act ? 1'b0 : (ap_act ? 1'b1 : store_q);
	// pin level seen by the array; the shared mux passes one of the two pins
	wire pin_lvl = cfg_reg[`PMC_B_DUAL] ? IO_PIN2_I : IO_PIN_I;
	wire pfb_out = PT_PIN_FB_REG_ARESET_I ? 1'b0 : (PT_PIN_FB_REG_APRESET_I ? 1'b1 : pfb_reg);
	wire pfb_lat_q = PT_PIN_FB_REG_CLK_I ? pin_lvl : pfb_lat_reg;
	wire in_lat_q = com_clk ? IN_PIN_I : in_lat_reg;

	// storage element next state on the selected cell clock edge
	always @* begin
		q_next = q_reg;
		if (ar_act) begin
			q_next = 1'b0;
		end else if (ap_act) begin
			q_next = 1'b1;
		end else if (clk_rise) begin
			if (PT_SR_I) begin
				q_next = 1'b0;
			end else if (PT_SP_I) begin
				q_next = 1'b1;
			end else begin
				case (st_type)
					`PMC_T_D: q_next = PT_D_I;
					`PMC_T_DCE: q_next = PT_CE_I ? PT_D_I : q_reg;
					// a tied-low input leaves the other one acting alone
					`PMC_T_JK: q_next = (PT_D_I & ~q_reg) | (~PT_K_I & q_reg);
					// both S and R high holds, the safest reading of an illegal pair
					`PMC_T_SR: q_next = PT_D_I ? ~PT_K_I | q_reg : (q_reg & ~PT_K_I);
					`PMC_T_T: q_next = PT_D_I ? ~q_reg : q_reg;
					default: q_next = q_reg;
				endcase
			end
		end
	end

	// pin feedback register with its own clock and controls
	always @* begin
		pfb_next = pfb_reg;
		if (PT_PIN_FB_REG_ARESET_I) begin
			pfb_next = 1'b0;
		end else if (PT_PIN_FB_REG_APRESET_I) begin
			pfb_next = 1'b1;
		end else if (pfb_rise) begin
			if (PT_PIN_FB_REG_SRESET_I) begin
				pfb_next = 1'b0;
			end else if (PT_PIN_FB_REG_SPRESET_I) begin
				pfb_next = 1'b1;
			end else begin
				pfb_next = pin_lvl;
			end
		end
	end

	// feedback into the array; default follows how the output is used
	always @* begin
		case (fb_mode)
			`PMC_FB_DEF: fb_sel = is_comb ? PT_D_I : q_out;
			`PMC_FB_REG: fb_sel = q_reg;
			`PMC_FB_LAT: fb_sel = latch_q;
			`PMC_FB_TOG: fb_sel = q_reg;
			`PMC_FB_INT: fb_sel = PT_D_I;
			`PMC_FB_PIN: fb_sel = pin_lvl;
			`PMC_FB_PREG: fb_sel = pfb_out;
			`PMC_FB_PLAT: fb_sel = pfb_lat_q;
			default: fb_sel = q_out;
		endcase
	end

	// macrocell state; the register keeps clocking even when the output is combinational
	always @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			q_reg <= 1'b0;
			latch_reg <= 1'b0;
			clk_prev_reg <= 1'b0;
			pfb_reg <= 1'b0;
			pfb_lat_reg <= 1'b0;
			pfb_clk_prev_reg <= 1'b0;
			in_reg <= 1'b0;
			in_lat_reg <= 1'b0;
		end else begin
			q_reg <= q_next;
			latch_reg <= ar_act ? 1'b0 : (ap_act ? 1'b1 : latch_q);
			clk_prev_reg <= cell_clk;
			pfb_reg <= pfb_next;
			pfb_lat_reg <= pfb_lat_q;
			pfb_clk_prev_reg <= PT_PIN_FB_REG_CLK_I;
			// input register clocks on the same cell clock edge as the output register, common or term clock
			if (com_clk & ~clk_prev_reg & ck_com) begin
				in_reg <= IN_PIN_I;
			end else if (~ck_com & clk_rise) begin
				in_reg <= IN_PIN_I;
			end
			in_lat_reg <= in_lat_q;
		end
	end

	assign IO_PIN_O = is_comb ? PT_D_I : q_out;
	assign IO_PIN_OE_O = cell_oe;
	assign FB_O = fb_sel;
	assign IN_FB_O = cfg_reg[`PMC_B_IN_LAT] ? in_lat_q : in_reg;

	// AXI4-Lite handshakes; one write and one read in flight
	wire aw_take = S_AXI_AWVALID_I & ~aw_have_reg & ~bvalid_reg;
	wire w_take = S_AXI_WVALID_I & ~w_have_reg & ~bvalid_reg;
	wire wr_go = aw_have_reg & w_have_reg & ~bvalid_reg;
	wire ar_take = S_AXI_ARVALID_I & ~rvalid_reg;
	wire wr_cfg = (awaddr_reg[`PMC_AW-1:2] == `PMC_OFF_CFG >> 2);
	wire wr_ctrl = (awaddr_reg[`PMC_AW-1:2] == `PMC_OFF_CTRL >> 2);

	assign S_AXI_AWREADY_O = ~aw_have_reg & ~bvalid_reg;
	assign S_AXI_WREADY_O = ~w_have_reg & ~bvalid_reg;
	assign S_AXI_BVALID_O = bvalid_reg;
	assign S_AXI_BRESP_O = bresp_reg;
	assign S_AXI_ARREADY_O = ~rvalid_reg;
	assign S_AXI_RVALID_O = rvalid_reg;
	assign S_AXI_RRESP_O = rresp_reg;
	assign S_AXI_RDATA_O = rdata_reg;

	// write side; the configuration is frozen while running
	always @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			cfg_reg <= `PMC_CFG_RST;
			run_reg <= 1'b0;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= {`PMC_AW{1'b0}};
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `PMC_RESP_OK;
		end else begin
			if (aw_take) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= S_AXI_AWADDR_I;
			end
			if (w_take) begin
				w_have_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA_I;
				wstrb_reg <= S_AXI_WSTRB_I;
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= `PMC_RESP_OK;
				if (wr_cfg & ~run_reg) begin
					cfg_reg <= merge(cfg_reg, wdata_reg, wstrb_reg);
				end else if (wr_ctrl) begin
					run_reg <= wstrb_reg[0] ? wdata_reg[0] : run_reg;
				end else begin
					bresp_reg <= `PMC_RESP_ERR;
				end
			end else if (bvalid_reg & S_AXI_BREADY_I) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// read side; status shows the cell's live state
	always @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			rvalid_reg <= 1'b0;
			rresp_reg <= `PMC_RESP_OK;
			rdata_reg <= 32'h0000_0000;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= `PMC_RESP_OK;
			case (S_AXI_ARADDR_I[`PMC_AW-1:2])
				`PMC_OFF_CFG >> 2: rdata_reg <= cfg_reg;
				`PMC_OFF_CTRL >> 2: rdata_reg <= {31'h0000_0000, run_reg};
				`PMC_OFF_STAT >> 2: rdata_reg <= {25'h000_0000, latch_q, pfb_out, IN_FB_O,
					fb_sel, cell_oe, IO_PIN_O, q_out};
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= `PMC_RESP_ERR;
				end
			endcase
		end else if (rvalid_reg & S_AXI_RREADY_I) begin
			rvalid_reg <= 1'b0;
		end
	end

endmodule

// ---- verilog/pmc_defines.vh ----
// Purpose: constants for the output macrocell and its register port
// Assumes: 32-bit AXI4-Lite data, 8-bit byte address
// Notes: field positions index the configuration word
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH
`define PMC_AW 8
`define PMC_OFF_CFG 8'h00
`define PMC_OFF_CTRL 8'h04
`define PMC_OFF_STAT 8'h08
`define PMC_CFG_RST 32'h0000_0000
`define PMC_RESP_OK 2'b00
`define PMC_RESP_ERR 2'b10
`define PMC_TYPE_LSB 0
`define PMC_TYPE_MSB 2
`define PMC_B_COMB 3
`define PMC_B_CK_COM 4
`define PMC_CK_LSB 5
`define PMC_B_CK_INV 7
`define PMC_B_OE_COM 8
`define PMC_OE_LSB 9
`define PMC_B_OE_INV 11
`define PMC_B_AP_PIN 12
`define PMC_AP_LSB 13
`define PMC_B_AR_PIN 15
`define PMC_AR_LSB 16
`define PMC_B_LE_PIN 18
`define PMC_LE_LSB 19
`define PMC_FB_LSB 21
`define PMC_FB_MSB 23
`define PMC_B_DUAL 24
`define PMC_B_IN_LAT 25
`define PMC_T_D 3'h0
`define PMC_T_DCE 3'h1
`define PMC_T_JK 3'h2
`define PMC_T_SR 3'h3
`define PMC_T_T 3'h4
`define PMC_T_LAT 3'h5
`define PMC_FB_DEF 3'h0
`define PMC_FB_REG 3'h1
`define PMC_FB_LAT 3'h2
`define PMC_FB_TOG 3'h3
`define PMC_FB_INT 3'h4
`define PMC_FB_PIN 3'h5
`define PMC_FB_PREG 3'h6
`define PMC_FB_PLAT 3'h7
`endif

// ---- verification/pmc_checker.sv ----
// Purpose: port-level checks of the output macrocell
// Assumes: one clock, synchronous active-low reset
// Notes: cell checks hold only while the config is still at reset
module pmc_checker (
	input wire CLOCK_I,
	input wire RSTN_I,
	input wire S_AXI_AWVALID_I,
	input wire S_AXI_AWREADY_O,
	input wire S_AXI_WVALID_I,
	input wire S_AXI_WREADY_O,
	input wire S_AXI_BVALID_O,
	input wire S_AXI_BREADY_I,
	input wire S_AXI_ARVALID_I,
	input wire S_AXI_ARREADY_O,
	input wire S_AXI_RVALID_O,
	input wire S_AXI_RREADY_I,
	input wire PT_OE_I,
	input wire PT_AR_I,
	input wire IO_PIN_O,
	input wire IO_PIN_OE_O,
	input wire FB_O
);
	logic clean_reg;
	default clocking @(posedge CLOCK_I);
	endclocking
	default disable iff (!RSTN_I);
	// conservative: cleared at the take, before the config can change
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I)
			clean_reg <= 1'h1;
		else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
			clean_reg <= 1'h0;
	end
	sequence s_both;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	sequence s_late_b;
		!S_AXI_BVALID_O ##1 S_AXI_BVALID_O;
	endsequence
	a_write_answer: assert property (s_both |=> s_late_b)
		else $error("write answer late");
	a_busy_refuse: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
		else $error("ready during response");
	a_ready_back: assert property ($fell(S_AXI_BVALID_O) |-> S_AXI_AWREADY_O && S_AXI_WREADY_O)
		else $error("ready not back");
	a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
		else $error("read answer late");
	a_read_clears: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
		else $error("rvalid stuck");
	a_oe_pterm: assert property (clean_reg |-> IO_PIN_OE_O == PT_OE_I)
		else $error("enable not from term");
	a_areset_now: assert property (clean_reg && PT_AR_I |-> !IO_PIN_O)
		else $error("reset term not immediate");
	a_fb_default: assert property (clean_reg |-> FB_O == IO_PIN_O)
		else $error("default feedback wrong");
endmodule
bind pmc_macrocell pmc_checker u_chk (.*);

// ---- verification/pmc_pin_model.sv ----
// Purpose: pin side of the macrocell, gives the I/O wire level
// Assumes: only the cell drives the pin, while its enable is high
// Notes: no keeper, a released pin shows the inverse of its last level
module pmc_pin_model (
	input wire logic clk_i,
	input wire logic drv_i,
	input wire logic oe_i,
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_reg;
	// a floating pin must never pass for a held value
	always_ff @(posedge clk_i) begin
		last_reg <= pin_o;
	end
	assign pin_o = oe_i ? drv_i : !last_reg;
endmodule

// ---- verification/pmc_tb.sv ----
// Purpose: self-checking bench for the output macrocell
// Assumes: s bits 0-14 are the terms, 15-18 common pins, 19 pin2, 20 input pin
// Notes: cell clocks are toggle pairs of s bits
`include "pmc_defines.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ck = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic [7:0] awa = '0, ara = '0;
	logic [31:0] wd = '0;
	logic [20:0] s = '0;
	wire awr, wrd, bv, arr, rv, io, oe, fb, ifb, pin;
	wire [1:0] bre, rre;
	wire [31:0] rda;
	int miscompares = 0, total_checks = 0;
	always #2.5 ck = !ck;
	pmc_macrocell dut (.CLOCK_I(ck), .RSTN_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(bre), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rda),
		.S_AXI_RRESP_O(rre), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .COMMON_PINS_I(s[18:15]),
		.PT_D_I(s[0]), .PT_K_I(s[1]), .PT_CE_I(s[2]), .PT_CLK_I(s[3]), .PT_OE_I(s[4]),
		.PT_AP_I(s[5]), .PT_AR_I(s[6]), .PT_SP_I(s[7]), .PT_SR_I(s[8]), .PT_LE_I(s[9]),
		.PT_PIN_FB_REG_CLK_I(s[10]), .PT_PIN_FB_REG_APRESET_I(s[11]), .PT_PIN_FB_REG_ARESET_I(s[12]), .PT_PIN_FB_REG_SPRESET_I(s[13]),
		.PT_PIN_FB_REG_SRESET_I(s[14]), .IO_PIN_I(pin), .IO_PIN2_I(s[19]), .IO_PIN_O(io), .IO_PIN_OE_O(oe),
		.IN_PIN_I(s[20]), .FB_O(fb), .IN_FB_O(ifb));
	pmc_pin_model u_pin (.clk_i(ck), .drv_i(io), .oe_i(oe), .pin_o(pin));
	// compare and count
	task chk(input string n, input logic [31:0] e, input logic [31:0] v);
		total_checks++;
		if (v !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, v);
		end
	endtask
	// verdict, also the way out of a hung wait
	task finish_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one write, address and data offered together
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		@(posedge ck);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		br <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge ck);
			if (awv && awr) awv <= 0;
			if (wv && wrd) wv <= 0;
			if (bv) break;
		end
		br <= 0;
		chk("bresp", e, bre);
		chk("answer", 0, n == 40);
		if (n == 40) finish_test();
	endtask
	// one read
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		int n;
		@(posedge ck);
		ara <= a;
		arv <= 1;
		rr <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge ck);
			if (arv && arr) arv <= 0;
			if (rv) break;
		end
		rr <= 0;
		chk("rdata", e, rda);
		chk("rresp", r, rre);
		chk("answer", 0, n == 40);
		if (n == 40) finish_test();
	endtask
	// cell stimulus helpers: drv sets a bit, tick gives one clock toggle pair
	task cf(input logic [31:0] d);
		wr(`PMC_OFF_CFG, d, `PMC_RESP_OK);
	endtask
	task drv(input int b, input logic v);
		@(posedge ck) s[b] <= v;
		@(posedge ck) #1;
	endtask
	task tick(input int b);
		@(posedge ck) s[b] <= !s[b];
		@(posedge ck) s[b] <= !s[b];
		@(posedge ck) #1;
	endtask
	// reset config: term clock, term enable, async terms
	task s_defaults();
		rd(`PMC_OFF_CFG, `PMC_CFG_RST, `PMC_RESP_OK);
		drv(4, 1);
		chk("oe", 1, oe);
		drv(0, 1);
		tick(3);
		chk("q", 1, io);
		chk("fb", 1, fb);
		drv(6, 1);
		chk("q", 0, io);
		drv(6, 0);
		drv(5, 1);
		chk("q", 1, io);
		drv(5, 0);
	endtask
	// register access and the run lock
	task s_regs();
		cf(32'h0000_0004);
		rd(8'h0c, 32'h0000_0000, `PMC_RESP_ERR);
		wr(`PMC_OFF_CTRL, 32'h0000_0001, `PMC_RESP_OK);
		wr(`PMC_OFF_CFG, 32'h0000_0000, `PMC_RESP_ERR);
		rd(`PMC_OFF_CFG, 32'h0000_0004, `PMC_RESP_OK);
		wr(`PMC_OFF_CTRL, 32'h0000_0000, `PMC_RESP_OK);
	endtask
	// storage types, starting from toggle with q high and T high
	task s_types();
		tick(3);
		chk("t", 0, io);
		drv(0, 0);
		tick(3);
		chk("t", 0, io);
		cf(32'h0000_0002);
		drv(0, 1);
		tick(3);
		chk("jk", 1, io);
		cf(32'h0000_0001);
		drv(0, 0);
		tick(3);
		chk("ce", 1, io);
		drv(2, 1);
		tick(3);
		chk("ce", 0, io);
		cf(32'h0000_0000);
		drv(0, 1);
		drv(8, 1);
		tick(3);
		chk("sr", 0, io);
		drv(8, 0);
		drv(7, 1);
		tick(3);
		chk("sp", 1, io);
		drv(7, 0);
		cf(32'h0000_0005);
		drv(0, 0);
		drv(9, 1);
		chk("lat", 0, io);
		drv(0, 1);
		drv(9, 0);
		drv(0, 0);
		chk("lat", 1, io);
	endtask
	// common pin clock (inverted), enable and async controls
	task s_mux();
		drv(17, 1);
		cf(32'h0000_00d0);
		tick(3);
		chk("ck", 1, io);
		tick(17);
		chk("ck", 0, io);
		drv(4, 0);
		drv(16, 1);
		cf(32'h0000_0300);
		chk("oe", 1, oe);
		cf(32'h0000_0b00);
		chk("oe", 0, oe);
		cf(32'h0000_7000);
		drv(18, 1);
		chk("ap", 1, io);
		drv(18, 0);
		cf(32'h0001_8000);
		chk("ar", 0, io);
		drv(16, 0);
	endtask
	// feedback paths, q low and terms low except CE on entry
	task s_fb();
		cf(32'h0080_0000);
		drv(0, 1);
		chk("int", 1, fb);
		drv(0, 0);
		// drive the pin so the level fed back is known, then preset it high
		cf(32'h00a0_0000);
		drv(4, 1);
		chk("pin", 0, fb);
		drv(5, 1);
		chk("pin", 1, fb);
		drv(5, 0);
		cf(32'h01a0_0000);
		chk("dual", 0, fb);
		cf(32'h00c0_0000);
		tick(10);
		chk("preg", 1, fb);
		drv(12, 1);
		chk("preg", 0, fb);
		drv(12, 0);
		cf(32'h0020_0008);
		chk("comb", 0, io);
		chk("regfb", 1, fb);
		cf(32'h0000_0000);
		drv(20, 1);
		tick(3);
		chk("in", 1, ifb);
		// live status: oe, input element and held latch high, the rest low
		rd(`PMC_OFF_STAT, 32'h0000_0054, `PMC_RESP_OK);
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge ck);
		rst_n <= 1;
		s_defaults();
		s_regs();
		s_types();
		s_mux();
		s_fb();
		finish_test();
	end
endmodule
